// ===== retbit_pkg.sv
package retbit_pkg;

    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [9:0] OP_INT_RETURN  = 10'h046;
    localparam logic [9:0] OP_SUB_RET_SKP = 10'h045;
    localparam logic [9:0] OP_CLR_UPPER   = 10'h058;
    localparam logic [9:0] OP_SET_UPPER   = 10'h059;
    localparam logic [9:0] OP_SET_BIT     = 10'h05C;
    localparam logic [9:0] OP_SET_BIT_MSK = 10'h3FC;
    localparam logic [9:0] OP_TABLE_REF   = 10'h080;
    localparam logic [9:0] OP_TABLE_MSK   = 10'h3C0;

    // ************************************************************
    // Register offsets and fields
    // ************************************************************
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_STACK_PTR = 4'h1;
    localparam logic [3:0] REG_PC        = 4'h2;
    localparam logic [3:0] REG_STACK     = 4'h3;
    localparam logic [3:0] REG_DATA_PTR  = 4'h4;
    localparam logic [3:0] REG_ACC       = 4'h5;
    localparam logic [3:0] REG_MEM       = 4'h6;

    localparam int CTRL_UPPER_BIT = 0;
    localparam int CTRL_SKIP_BIT  = 1;
    localparam int CTRL_NOPM_BIT  = 2;
    localparam int DATA_PTR_Y_LSB = 0;
    localparam int DATA_PTR_X_LSB = 4;
    localparam int DATA_PTR_Z_LSB = 8;
    localparam int ACC_A_LSB      = 0;
    localparam int ACC_B_LSB      = 4;
    localparam int ACC_CARRY_BIT  = 8;

    localparam logic [15:0] RDATA_UNMAPPED = 16'h0000;
    localparam logic        UPPER_RESET    = 1'b0;

    // ************************************************************
    // Context saved at interrupt entry
    // ************************************************************
    typedef struct packed {
        logic [1:0] z;
        logic [3:0] x;
        logic [3:0] y;
        logic       carry;
        logic       skip;
        logic       nopm;
        logic [3:0] a;
        logic [3:0] b;
    } ctx_t;

    localparam ctx_t CTX_RESET = '0;

    typedef enum logic { RET_SUB_SKIP, RET_INT } ret_kind_t;

endpackage

// ===== ctx_bank.sv
`timescale 1ns/10ps

module ctx_bank
(
    input  wire logic              clk_in,   // Core clock.
    input  wire logic              rst_in,   // Synchronous reset.
    input  wire logic              save_in,  // Capture pulse.
    input  wire retbit_pkg::ctx_t  live_in,  // Current context.
    output retbit_pkg::ctx_t       saved_out // Held context.
);

    retbit_pkg::ctx_t saved_r;

    // One level is enough: interrupts do not nest on this core.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            saved_r <= retbit_pkg::CTX_RESET;
        else if (save_in)
            saved_r <= live_in;
    end

    assign saved_out = saved_r;

endmodule

// ===== retbit_core.sv
`timescale 1ns/10ps


module retbit_core
#(
    parameter int PC_W        = 13,
    parameter int STACK_PTR_W = 3,
    parameter int MEM_AW      = 6
)
(
    input  wire logic              CLOCK_IN,        // Core clock.
    input  wire logic              RESET_IN,        // Sync reset, high.
    input  wire logic [9:0]        INSTR_IN,        // Instruction word.
    input  wire logic              INSTR_VALID_IN,  // Instruction present.
    output logic                   INSTR_READY_OUT, // Ready for next word.
    input  wire logic [9:0]        TABLE_DATA_IN,   // ROM reference data.
    input  wire logic              CTX_SAVE_IN,     // Interrupt entry pulse.
    input  wire logic [3:0]        REG_ADDR_IN,     // Register address.
    input  wire logic [15:0]       REG_WDATA_IN,    // Register write data.
    input  wire logic              REG_WR_IN,       // Write strobe.
    input  wire logic              REG_RD_IN,       // Read strobe.
    output logic [15:0]            REG_RDATA_OUT,   // Read data, next cycle.
    output logic [PC_W-1:0]        PC_OUT,          // Program counter.
    output logic [1:0]             TABLE_HI_OUT,    // Upper table bits.
    output logic                   CARRY_OUT        // Carry flag.
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] { ST_FETCH, ST_RET } state_t;

    state_t                 state_r;
    retbit_pkg::ret_kind_t  ret_kind_r;
    logic [PC_W-1:0]        pc_r;
    logic [STACK_PTR_W-1:0] stack_ptr_r;
    logic [PC_W-1:0]        stack_r [2**STACK_PTR_W];
    logic [3:0]             mem_r [2**MEM_AW];
    logic [3:0]             x_r;
    logic [3:0]             y_r;
    logic [1:0]             z_r;
    logic [3:0]             a_r;
    logic [3:0]             b_r;
    logic                   carry_r;
    logic                   ready_r;
    logic                   skip_r;
    logic                   nopm_r;
    logic                   upper_r;
    logic [1:0]             table_hi_r;
    logic [15:0]            rdata_r;
    retbit_pkg::ctx_t       live_ctx;
    retbit_pkg::ctx_t       saved_ctx;

    // ************************************************************
    // Decode
    // ************************************************************
    wire take     = INSTR_VALID_IN && ready_r;
    wire exec     = take && !skip_r;
    wire is_iret  = INSTR_IN == retbit_pkg::OP_INT_RETURN;
    wire is_rts   = INSTR_IN == retbit_pkg::OP_SUB_RET_SKP;
    wire is_clru  = INSTR_IN == retbit_pkg::OP_CLR_UPPER;
    wire is_setu  = INSTR_IN == retbit_pkg::OP_SET_UPPER;
    wire is_setb  = (INSTR_IN & retbit_pkg::OP_SET_BIT_MSK)
                    == retbit_pkg::OP_SET_BIT;
    wire is_tab   = (INSTR_IN & retbit_pkg::OP_TABLE_MSK)
                    == retbit_pkg::OP_TABLE_REF;
    wire is_ret   = is_iret || is_rts;

    wire [MEM_AW-1:0]      mem_idx  = MEM_AW'({z_r, x_r, y_r});
    wire [3:0]             mem_rd   = mem_r[mem_idx];
    wire [3:0]             bit_mask = 4'h1 << INSTR_IN[1:0];
    wire [PC_W-1:0]        ret_pc   = stack_r[stack_ptr_r];
    wire [PC_W-1:0]        pc_inc   = PC_W'(pc_r + 1'b1);
    wire [STACK_PTR_W-1:0] ptr_dec  = STACK_PTR_W'(stack_ptr_r - 1'b1);

    wire wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_CTRL);
    wire wr_ptr   = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_STACK_PTR);
    wire wr_pc    = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_PC);
    wire wr_stack = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_STACK);
    wire wr_dptr  = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_DATA_PTR);
    wire wr_acc   = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_ACC);
    wire wr_mem   = REG_WR_IN && (REG_ADDR_IN == retbit_pkg::REG_MEM);

    wire [15:0] rd_ctrl = 16'({nopm_r, skip_r, upper_r});
    wire [15:0] rd_dptr = 16'({z_r, x_r, y_r});
    wire [15:0] rd_acc  = 16'({carry_r, b_r, a_r});
    wire [15:0] rd_mux  =
        (REG_ADDR_IN == retbit_pkg::REG_CTRL)      ? rd_ctrl :
        (REG_ADDR_IN == retbit_pkg::REG_STACK_PTR) ? 16'(stack_ptr_r) :
        (REG_ADDR_IN == retbit_pkg::REG_PC)        ? 16'(pc_r) :
        (REG_ADDR_IN == retbit_pkg::REG_STACK)     ? 16'(ret_pc) :
        (REG_ADDR_IN == retbit_pkg::REG_DATA_PTR)  ? rd_dptr :
        (REG_ADDR_IN == retbit_pkg::REG_ACC)       ? rd_acc :
        (REG_ADDR_IN == retbit_pkg::REG_MEM)       ? 16'(mem_rd) :
        retbit_pkg::RDATA_UNMAPPED;

    assign live_ctx = '{z: z_r, x: x_r, y: y_r, carry: carry_r,
                        skip: skip_r, nopm: nopm_r, a: a_r, b: b_r};

    ctx_bank u_ctx
    (
        .clk_in    (CLOCK_IN),
        .rst_in    (RESET_IN),
        .save_in   (CTX_SAVE_IN),
        .live_in   (live_ctx),
        .saved_out (saved_ctx)
    );

    // ************************************************************
    // Sequencer and program counter
    // ************************************************************
    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
        begin
            state_r     <= ST_FETCH;
            ready_r     <= 1'b1;
            ret_kind_r  <= retbit_pkg::RET_SUB_SKIP;
            pc_r        <= '0;
            stack_ptr_r <= '0;
        end
        else
        begin
            if (wr_ptr)
                stack_ptr_r <= STACK_PTR_W'(REG_WDATA_IN);
            if (wr_pc)
                pc_r <= PC_W'(REG_WDATA_IN);
            if (take)
                pc_r <= pc_inc;
            if (exec && is_ret)
            begin
                state_r    <= ST_RET;
                ready_r    <= 1'b0;
                ret_kind_r <= is_iret ? retbit_pkg::RET_INT
                                      : retbit_pkg::RET_SUB_SKIP;
            end
            if (state_r == ST_RET)
            begin
                state_r     <= ST_FETCH;
                ready_r     <= 1'b1;
                pc_r        <= ret_pc;
                stack_ptr_r <= ptr_dec;
            end
        end
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (wr_stack)
            stack_r[stack_ptr_r] <= PC_W'(REG_WDATA_IN);
    end

    // ************************************************************
    // Data pointer, accumulator and flags
    // ************************************************************
    // Execution has the last word over a register write in the same cycle.
    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
        begin
            {z_r, x_r, y_r} <= '0;
            {carry_r, b_r, a_r} <= '0;
            skip_r     <= 1'b0;
            nopm_r     <= 1'b0;
            upper_r    <= retbit_pkg::UPPER_RESET;
            table_hi_r <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                upper_r <= REG_WDATA_IN[retbit_pkg::CTRL_UPPER_BIT];
                skip_r  <= REG_WDATA_IN[retbit_pkg::CTRL_SKIP_BIT];
                nopm_r  <= REG_WDATA_IN[retbit_pkg::CTRL_NOPM_BIT];
            end
            if (wr_dptr)
            begin
                y_r <= REG_WDATA_IN[retbit_pkg::DATA_PTR_Y_LSB +: 4];
                x_r <= REG_WDATA_IN[retbit_pkg::DATA_PTR_X_LSB +: 4];
                z_r <= REG_WDATA_IN[retbit_pkg::DATA_PTR_Z_LSB +: 2];
            end
            if (wr_acc)
            begin
                a_r     <= REG_WDATA_IN[retbit_pkg::ACC_A_LSB +: 4];
                b_r     <= REG_WDATA_IN[retbit_pkg::ACC_B_LSB +: 4];
                carry_r <= REG_WDATA_IN[retbit_pkg::ACC_CARRY_BIT];
            end
            if (take && skip_r)
                skip_r <= 1'b0;
            if (exec && is_clru)
                upper_r <= 1'b0;
            if (exec && is_setu)
                upper_r <= 1'b1;
            if (exec && is_tab)
            begin
                a_r        <= TABLE_DATA_IN[3:0];
                b_r        <= TABLE_DATA_IN[7:4];
                table_hi_r <= upper_r ? TABLE_DATA_IN[9:8] : 2'h0;
            end
            if (state_r == ST_RET && ret_kind_r == retbit_pkg::RET_SUB_SKIP)
                skip_r <= 1'b1;
            if (state_r == ST_RET && ret_kind_r == retbit_pkg::RET_INT)
            begin
                {z_r, x_r, y_r} <= {saved_ctx.z, saved_ctx.x, saved_ctx.y};
                a_r     <= saved_ctx.a;
                b_r     <= saved_ctx.b;
                carry_r <= saved_ctx.carry;
                skip_r  <= saved_ctx.skip;
                nopm_r  <= saved_ctx.nopm;
            end
        end
    end

    // ************************************************************
    // Data memory
    // ************************************************************
    always_ff @(posedge CLOCK_IN)
    begin
        if (wr_mem)
            mem_r[mem_idx] <= REG_WDATA_IN[3:0];
        if (exec && is_setb)
            mem_r[mem_idx] <= mem_rd | bit_mask;
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge CLOCK_IN)
    begin
        if (RESET_IN)
            rdata_r <= retbit_pkg::RDATA_UNMAPPED;
        else if (REG_RD_IN)
            rdata_r <= rd_mux;
        else
            rdata_r <= retbit_pkg::RDATA_UNMAPPED;
    end

    assign INSTR_READY_OUT = ready_r;
    assign REG_RDATA_OUT   = rdata_r;
    assign PC_OUT          = pc_r;
    assign TABLE_HI_OUT    = table_hi_r;
    assign CARRY_OUT       = carry_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    sequence ret_issue;
        exec && is_ret;
    endsequence

    sequence ret_finish;
        (state_r == ST_RET) ##1 (state_r == ST_FETCH);
    endsequence

    AST_RET_TWO_CYCLES:
        assert property (ret_issue |=> ret_finish)
        else $error("Return did not finish in two cycles.");

    AST_RET_POP:
        assert property ((state_r == ST_RET) |=>
            (pc_r == $past(ret_pc)) &&
            (stack_ptr_r == STACK_PTR_W'($past(stack_ptr_r) - 1'b1)))
        else $error("Return did not pop the stack.");

    AST_IRET_RESTORE:
        assert property ((state_r == ST_RET &&
                          ret_kind_r == retbit_pkg::RET_INT) |=>
            (a_r == $past(saved_ctx.a)) && (b_r == $past(saved_ctx.b)) &&
            (x_r == $past(saved_ctx.x)) && (skip_r == $past(saved_ctx.skip)))
        else $error("Interrupt return lost saved context.");

    AST_RTS_SKIP:
        assert property ((exec && is_rts) |=> ##1 skip_r)
        else $error("Subroutine return did not arm skip.");

    AST_CLR_UPPER:
        assert property ((exec && is_clru) |=> !upper_r)
        else $error("Upper reference flag not cleared.");

    AST_TABLE_HI:
        assert property ((exec && is_tab && !upper_r) |=> table_hi_r == 2'h0)
        else $error("Upper table bits delivered while disabled.");

    AST_SET_BIT:
        assert property ((exec && is_setb) |=>
            mem_r[$past(mem_idx)] == ($past(mem_rd) | $past(bit_mask)))
        else $error("Set-bit result wrong.");

    AST_CARRY_KEPT:
        assert property ((exec && (is_clru || is_setb || is_ret) && !wr_acc)
            |=> carry_r == $past(carry_r))
        else $error("Carry changed by a non-carry operation.");

endmodule

// ===== testbench.sv
`timescale 1ns/10ps

module testbench;

    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [9:0]  instr = 10'h000;
    logic        valid = 1'b0;
    logic        ready;
    logic [9:0]  tbl   = 10'h000;
    logic        save  = 1'b0;
    logic [3:0]  addr  = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [15:0] rdata;
    logic [12:0] pc;
    logic [1:0]  tbl_hi;
    logic        carry;
    int          miscompares = 0;
    int          checked     = 0;

    always #2 clk = ~clk;

    retbit_core DUT
    (
        .CLOCK_IN        (clk),
        .RESET_IN        (rst),
        .INSTR_IN        (instr),
        .INSTR_VALID_IN  (valid),
        .INSTR_READY_OUT (ready),
        .TABLE_DATA_IN   (tbl),
        .CTX_SAVE_IN     (save),
        .REG_ADDR_IN     (addr),
        .REG_WDATA_IN    (wdata),
        .REG_WR_IN       (wr),
        .REG_RD_IN       (rd),
        .REG_RDATA_OUT   (rdata),
        .PC_OUT          (pc),
        .TABLE_HI_OUT    (tbl_hi),
        .CARRY_OUT       (carry)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic print_verdict;
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_value(input logic [15:0] got,
                               input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp,
                          input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check_value(rdata, exp, what);
    endtask

    // A hung sequencer must end the run rather than stall it.
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 20)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: sequencer never ready", $time);
            print_verdict();
        end
    endtask

    task automatic issue(input logic [9:0] w);
        wait_ready();
        @(posedge clk);
        instr <= w;
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        #1;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_reset;
        reg_rd(retbit_pkg::REG_CTRL, 16'h0000, "ctrl reset");
        reg_rd(retbit_pkg::REG_STACK_PTR, 16'h0000, "ptr reset");
        reg_rd(retbit_pkg::REG_PC, 16'h0000, "pc reset");
        reg_wr(4'hF, 16'hFFFF);
        reg_rd(4'hF, retbit_pkg::RDATA_UNMAPPED, "unmapped");
        check_value({14'h0000, tbl_hi}, 16'h0000, "table hi reset");
    endtask

    task automatic test_set_bit;
        logic [15:0] exp;
        reg_wr(retbit_pkg::REG_ACC, 16'h0100);
        reg_wr(retbit_pkg::REG_DATA_PTR, 16'h0012);
        reg_wr(retbit_pkg::REG_MEM, 16'h0000);
        for (int j = 0; j < 4; j++)
        begin
            exp = 16'((1 << (j + 1)) - 1);
            issue(retbit_pkg::OP_SET_BIT | 10'(j));
            reg_rd(retbit_pkg::REG_MEM, exp, "set bit");
        end
        check_value({15'h0000, carry}, 16'h0001, "carry set bit");
    endtask

    task automatic test_upper_ref;
        @(posedge clk);
        tbl <= 10'h2C7;
        issue(retbit_pkg::OP_SET_UPPER);
        reg_rd(retbit_pkg::REG_CTRL, 16'h0001, "upper set");
        issue(retbit_pkg::OP_TABLE_REF | 10'h005);
        check_value({14'h0000, tbl_hi}, 16'h0002, "hi on");
        issue(retbit_pkg::OP_CLR_UPPER);
        reg_rd(retbit_pkg::REG_CTRL, 16'h0000, "upper clr");
        check_value({15'h0000, carry}, 16'h0001, "carry clr");
        issue(retbit_pkg::OP_TABLE_REF | 10'h005);
        check_value({14'h0000, tbl_hi}, 16'h0000, "hi off");
    endtask

    task automatic test_sub_return;
        reg_wr(retbit_pkg::REG_ACC, 16'h0100);
        reg_wr(retbit_pkg::REG_STACK_PTR, 16'h0002);
        reg_wr(retbit_pkg::REG_STACK, 16'h0123);
        reg_wr(retbit_pkg::REG_MEM, 16'h0000);
        issue(retbit_pkg::OP_SUB_RET_SKP);
        check_value({15'h0000, ready}, 16'h0000, "rts busy");
        @(posedge clk);
        #1;
        check_value({15'h0000, ready}, 16'h0001, "rts done");
        check_value({3'h0, pc}, 16'h0123, "rts pc");
        reg_rd(retbit_pkg::REG_STACK_PTR, 16'h0001, "rts ptr");
        reg_rd(retbit_pkg::REG_CTRL, 16'h0002, "rts skip");
        // The set-bit word below must be discarded by the pending skip.
        issue(retbit_pkg::OP_SET_BIT);
        reg_rd(retbit_pkg::REG_MEM, 16'h0000, "skipped op");
        reg_rd(retbit_pkg::REG_CTRL, 16'h0000, "skip cleared");
        check_value({3'h0, pc}, 16'h0124, "pc after skip");
        check_value({15'h0000, carry}, 16'h0001, "carry rts");
    endtask

    task automatic test_int_return;
        reg_wr(retbit_pkg::REG_DATA_PTR, 16'h0234);
        reg_wr(retbit_pkg::REG_ACC, 16'h01A5);
        // Skip and NOP mode are saved set, so that their restore is visible.
        reg_wr(retbit_pkg::REG_CTRL, 16'h0006);
        @(posedge clk);
        save <= 1'b1;
        @(posedge clk);
        save <= 1'b0;
        reg_wr(retbit_pkg::REG_CTRL, 16'h0000);
        reg_wr(retbit_pkg::REG_ACC, 16'h0000);
        reg_wr(retbit_pkg::REG_DATA_PTR, 16'h0000);
        reg_wr(retbit_pkg::REG_STACK_PTR, 16'h0003);
        reg_wr(retbit_pkg::REG_STACK, 16'h0ABC);
        check_value({15'h0000, carry}, 16'h0000, "carry cleared");
        issue(retbit_pkg::OP_INT_RETURN);
        check_value({15'h0000, ready}, 16'h0000, "iret busy");
        @(posedge clk);
        #1;
        check_value({15'h0000, ready}, 16'h0001, "iret done");
        check_value({3'h0, pc}, 16'h0ABC, "iret pc");
        check_value({15'h0000, carry}, 16'h0001, "iret carry");
        reg_rd(retbit_pkg::REG_STACK_PTR, 16'h0002, "iret ptr");
        reg_rd(retbit_pkg::REG_ACC, 16'h01A5, "iret acc");
        reg_rd(retbit_pkg::REG_DATA_PTR, 16'h0234, "iret dptr");
        reg_rd(retbit_pkg::REG_CTRL, 16'h0006, "iret ctrl");
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_set_bit();
        test_upper_ref();
        test_sub_return();
        test_int_return();
        print_verdict();
    end

endmodule
